// >>> rtl/bus_release_pkg.sv
// constants and types shared by the bus release and cache snoop block
package bus_release_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_BEATS = 4;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    IDLE_ST    = 3'h0,
    CYCLE_ST   = 3'h1,
    HOLD_ST    = 3'h2,
    BACKOFF_ST = 3'h3
  } bus_state_type;
endpackage

// >>> rtl/level_sync.sv
// two flip-flop synchroniser for an asynchronous level
module level_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> rtl/sample_reg.sv
// one-stage pin sampling register of parameterised width
module sample_reg #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end
endmodule

// >>> rtl/bus_release_snoop.sv
// processor bus ownership, backoff, address hold, snoop and cache control
// Notes on behaviour
// - grant rises in the same clock the bus outputs float for hold.
// - grant is always driven during hold and drops on leaving hold.
// - sampled backoff floats the bus on the next clock, mid-cycle.
// - backoff floats the hold pin set but never raises grant.
// - backoff together with a ready wins; the ready is ignored.
// - bus stays floated while backoff is held; resumes after negation.
// - a cycle cut by backoff is rerun from its start afterwards.
// - address hold request floats the address bus on the next clock.
// - address hold floats only the address bus; others keep driving.
// - external strobe during address hold starts an invalidation.
// - cache enable before first ready turns a cacheable cycle into a line fill.
// - cache enable before last ready lets the filled line be stored.
// - one clock of wipe request flushes the whole cache.
// - hold waits for cycle, burst or locked run; stays until withdrawn.
module bus_release_snoop
  import bus_release_pkg::*;
#(
  parameter int AW = bus_release_pkg::ADDR_W
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic BUS_RELEASE_REQUEST,
  input wire logic BACKOFF_N,
  input wire logic ADDRESS_RELEASE_REQUEST,
  input wire logic EXTERNAL_ADDRESS_STROBE_N,
  input wire logic CACHE_ENABLE_IN_N,
  input wire logic NONBURST_READY_N,
  input wire logic BURST_READY_N,
  input wire logic CACHE_WIPE_REQUEST_N,
  input wire logic [AW-1:0] ADDR_IN,
  input wire logic CYCLE_REQ,
  input wire logic CYCLE_CACHEABLE,
  input wire logic CYCLE_LOCKED,
  input wire logic [AW-1:0] CYCLE_ADDR,
  output logic CYCLE_DONE,
  output logic BUS_RELEASE_GRANT,
  output logic ADDR_OE,
  output logic CTRL_OE,
  output logic [AW-1:0] ADDR_OUT,
  output logic ADS_N,
  output logic LINE_FILL,
  output logic LINE_STORE,
  output logic INVALIDATE,
  output logic [AW-1:0] INVALIDATE_ADDR,
  output logic CACHE_FLUSH
);
  import bus_release_pkg::*;

  // ****************************************
  // input sampling
  // ****************************************
  logic hold_req_s;
  logic backoff_n_n_s;
  logic address_release_request_s;
  logic external_address_strobe_n_n_s;
  logic ken_n_s;
  logic rdy_n_s;
  logic burst_ready_n_n_s;
  logic wipe_n_s;
  logic [AW-1:0] addr_in_s;

  level_sync #(
    .RESET_VAL(1'b0)
  ) u_hold_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(BUS_RELEASE_REQUEST),
    .sync_out(hold_req_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_backoff_n_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(BACKOFF_N),
    .sync_out(backoff_n_n_s)
  );
  level_sync #(
    .RESET_VAL(1'b0)
  ) u_address_release_request_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(ADDRESS_RELEASE_REQUEST),
    .sync_out(address_release_request_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_external_address_strobe_n_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(EXTERNAL_ADDRESS_STROBE_N),
    .sync_out(external_address_strobe_n_n_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_ken_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(CACHE_ENABLE_IN_N),
    .sync_out(ken_n_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_rdy_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(NONBURST_READY_N),
    .sync_out(rdy_n_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_burst_ready_n_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(BURST_READY_N),
    .sync_out(burst_ready_n_n_s)
  );
  level_sync #(
    .RESET_VAL(1'b1)
  ) u_wipe_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in(CACHE_WIPE_REQUEST_N),
    .sync_out(wipe_n_s)
  );

  // snooped address takes the same two stages as its strobe
  logic [AW-1:0] addr_meta;
  sample_reg #(
    .WIDTH(AW),
    .RESET_VAL(ADDR_ZERO[AW-1:0])
  ) u_addr_meta (
    .clk(CORE_CLK),
    .rst(RESET),
    .d(ADDR_IN),
    .q(addr_meta)
  );
  sample_reg #(
    .WIDTH(AW),
    .RESET_VAL(ADDR_ZERO[AW-1:0])
  ) u_addr_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .d(addr_meta),
    .q(addr_in_s)
  );

  // ken history: value one clock before the current sample
  logic ken_prev_n;
  sample_reg #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_ken_prev (
    .clk(CORE_CLK),
    .rst(RESET),
    .d(ken_n_s),
    .q(ken_prev_n)
  );

  // ****************************************
  // decode
  // ****************************************
  bus_state_type state_q, state_d;
  logic [BEAT_W-1:0] beat_q, beat_d;
  logic fill_q, fill_d;
  logic locked_q, locked_d;
  logic pending_q, pending_d;
  logic [AW-1:0] cyc_addr_q, cyc_addr_d;
  logic address_release_request_q;

  wire backoff = ~backoff_n_n_s;
  wire ready_any = ~rdy_n_s | ~burst_ready_n_n_s;
  wire ready_taken = ready_any & ~backoff;
  wire first_beat = (beat_q == BEAT_ZERO);
  wire make_fill = first_beat & CYCLE_CACHEABLE & ~ken_prev_n;
  wire burst_more = fill_q | make_fill;
  wire last_beat = ~burst_more | (beat_q == LAST_BEAT);
  wire cycle_end = (state_q == CYCLE_ST) & ready_taken & last_beat;
  wire may_release = ~locked_q | ~CYCLE_LOCKED;
  wire start_cycle = (CYCLE_REQ | pending_q) & ~hold_req_s & ~backoff;

  // ****************************************
  // bus state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    beat_d = beat_q;
    fill_d = fill_q;
    locked_d = locked_q;
    pending_d = pending_q;
    cyc_addr_d = cyc_addr_q;
    unique case (state_q)
      IDLE_ST: begin
        if (backoff) begin
          state_d = BACKOFF_ST;
        end else if (hold_req_s & may_release) begin
          state_d = HOLD_ST;
        end else if (start_cycle) begin
          state_d = CYCLE_ST;
          beat_d = BEAT_ZERO;
          fill_d = 1'b0;
          locked_d = CYCLE_LOCKED;
          pending_d = 1'b1;
          if (!pending_q) begin
            cyc_addr_d = CYCLE_ADDR;
          end
        end
      end
      CYCLE_ST: begin
        if (backoff) begin
          state_d = BACKOFF_ST;
          beat_d = BEAT_ZERO;
          fill_d = 1'b0;
        end else if (ready_taken) begin
          if (last_beat) begin
            state_d = IDLE_ST;
            pending_d = 1'b0;
            beat_d = BEAT_ZERO;
            fill_d = 1'b0;
            if (!CYCLE_LOCKED) begin
              locked_d = 1'b0;
            end
          end else begin
            fill_d = burst_more;
            beat_d = beat_q + BEAT_ONE;
          end
        end
      end
      HOLD_ST: begin
        if (!hold_req_s) begin
          state_d = IDLE_ST;
        end
      end
      BACKOFF_ST: begin
        if (!backoff) begin
          state_d = IDLE_ST;
        end
      end
      default: begin
        state_d = IDLE_ST;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= IDLE_ST;
      beat_q <= BEAT_ZERO;
      fill_q <= 1'b0;
      locked_q <= 1'b0;
      pending_q <= 1'b0;
      cyc_addr_q <= ADDR_ZERO[AW-1:0];
      address_release_request_q <= 1'b0;
    end else begin
      state_q <= state_d;
      beat_q <= beat_d;
      fill_q <= fill_d;
      locked_q <= locked_d;
      pending_q <= pending_d;
      cyc_addr_q <= cyc_addr_d;
      address_release_request_q <= address_release_request_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire floated_d = (state_d == HOLD_ST) | (state_d == BACKOFF_ST);
  wire grant_d = (state_d == HOLD_ST);
  wire addr_oe_d = ~floated_d & ~address_release_request_s;
  wire ads_d = (state_q == IDLE_ST) & (state_d == CYCLE_ST);
  wire store_d = (state_q == CYCLE_ST) & cycle_end & fill_q & ~ken_prev_n;
  wire inval_d = address_release_request_q & ~external_address_strobe_n_n_s;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      BUS_RELEASE_GRANT <= 1'b0;
      ADDR_OE <= 1'b1;
      CTRL_OE <= 1'b1;
      ADDR_OUT <= ADDR_ZERO[AW-1:0];
      ADS_N <= 1'b1;
      CYCLE_DONE <= 1'b0;
      LINE_FILL <= 1'b0;
      LINE_STORE <= 1'b0;
      INVALIDATE <= 1'b0;
      INVALIDATE_ADDR <= ADDR_ZERO[AW-1:0];
      CACHE_FLUSH <= 1'b0;
    end else begin
      BUS_RELEASE_GRANT <= grant_d;
      CTRL_OE <= ~floated_d;
      ADDR_OE <= addr_oe_d;
      ADDR_OUT <= cyc_addr_d;
      ADS_N <= ~ads_d;
      CYCLE_DONE <= cycle_end & ~backoff;
      LINE_FILL <= (state_q == CYCLE_ST) & ready_taken & make_fill;
      LINE_STORE <= store_d;
      INVALIDATE <= inval_d;
      if (inval_d) begin
        INVALIDATE_ADDR <= addr_in_s;
      end
      CACHE_FLUSH <= ~wipe_n_s;
    end
  end
endmodule

// >>> dv/bus_release_snoop_props.sv
// port assertions for the bus release and snoop block
module bus_release_snoop_props (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic BUS_RELEASE_REQUEST,
  input wire logic BACKOFF_N,
  input wire logic ADDRESS_RELEASE_REQUEST,
  input wire logic EXTERNAL_ADDRESS_STROBE_N,
  input wire logic CACHE_WIPE_REQUEST_N,
  input wire logic BUS_RELEASE_GRANT,
  input wire logic ADDR_OE,
  input wire logic CTRL_OE,
  input wire logic ADS_N,
  input wire logic INVALIDATE,
  input wire logic CACHE_FLUSH
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_grant_floats_bus: assert property (BUS_RELEASE_GRANT |-> !CTRL_OE && !ADDR_OE)
    else $error("grant without floated bus");
  a_grant_drops: assert property ($fell(BUS_RELEASE_REQUEST) |-> ##[1:5] !BUS_RELEASE_GRANT)
    else $error("grant kept after hold withdrawn");
  a_backoff_floats: assert property ($fell(BACKOFF_N) |-> ##[1:5] !CTRL_OE)
    else $error("bus not floated on backoff");
  a_grant_needs_hold: assert property (BUS_RELEASE_GRANT |-> $past(BUS_RELEASE_REQUEST, 3))
    else $error("grant without hold request");
  a_backoff_stays: assert property (!BACKOFF_N [*5] |-> !CTRL_OE)
    else $error("bus driven during backoff");
  a_addr_floats: assert property ($rose(ADDRESS_RELEASE_REQUEST) |-> ##[1:5] !ADDR_OE)
    else $error("address bus kept in address hold");
  a_addr_hold_only: assert property ((ADDRESS_RELEASE_REQUEST && BACKOFF_N && !BUS_RELEASE_REQUEST) [*6]
    |-> CTRL_OE && !ADDR_OE)
    else $error("wrong pin set floated in address hold");
  a_snoop_starts: assert property (!EXTERNAL_ADDRESS_STROBE_N && ADDRESS_RELEASE_REQUEST
    && $past(ADDRESS_RELEASE_REQUEST, 4) |-> ##[1:5] INVALIDATE)
    else $error("no invalidation after strobe");
  a_flush_synced: assert property ($fell(CACHE_WIPE_REQUEST_N) |-> ##[2:5] $rose(CACHE_FLUSH))
    else $error("flush missing or unsynchronised");
  a_start_pulse: assert property (!ADS_N |=> ADS_N)
    else $error("cycle start longer than one clock");
endmodule
bind bus_release_snoop bus_release_snoop_props bus_release_snoop_props_i (.CORE_CLK, .RESET, .BUS_RELEASE_REQUEST,
  .BACKOFF_N, .ADDRESS_RELEASE_REQUEST, .EXTERNAL_ADDRESS_STROBE_N, .CACHE_WIPE_REQUEST_N, .BUS_RELEASE_GRANT,
  .ADDR_OE, .CTRL_OE, .ADS_N, .INVALIDATE, .CACHE_FLUSH);

// >>> dv/bus_target_model.sv
// memory side model: ready beats and cache enable
module bus_target_model (
  input wire logic clk,
  input wire logic ads_n,
  input wire logic [2:0] beats,
  input wire logic ken_first_n,
  input wire logic ken_last_n,
  output logic ready_n = 1'b1,
  output logic ken_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left_q = 3'h0;
  logic [1:0] wait_q = 2'h0;
  always @(posedge clk) begin
    ready_n <= #1 !(ads_n && wait_q == 2'h0 && left_q != 3'h0);
    if (!ads_n) begin
      left_q <= beats;
      wait_q <= 2'h3;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end
  end
  // enable set up one clock ahead of each beat
  assign #1 ken_n = (left_q == 3'h1) ? ken_last_n : ken_first_n;
endmodule

// >>> dv/bus_release_snoop_test.sv
// testbench for the bus release and snoop block
module bus_release_snoop_test;
  import bus_release_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 0, RESET = 1, BUS_RELEASE_REQUEST = 0, BACKOFF_N = 1, ADDRESS_RELEASE_REQUEST = 0;
  logic EXTERNAL_ADDRESS_STROBE_N = 1, CACHE_WIPE_REQUEST_N = 1, CYCLE_REQ = 0, CYCLE_CACHEABLE = 0;
  logic CYCLE_LOCKED = 0, kf = 1, kl = 1, rdy_n, CACHE_ENABLE_IN_N;
  logic [ADDR_W-1:0] ADDR_IN = '0, CYCLE_ADDR = '0, ADDR_OUT, INVALIDATE_ADDR, ads_a;
  logic CYCLE_DONE, BUS_RELEASE_GRANT, ADDR_OE, CTRL_OE, ADS_N, LINE_FILL, LINE_STORE, INVALIDATE, CACHE_FLUSH;
  logic [2:0] beats = 3'h1;
  int miscompares = 0, checked = 0, ads_c, fill_c, store_c, done_c, inv_c, fl_c;
  wire NONBURST_READY_N = rdy_n | (beats != 3'h1);
  wire BURST_READY_N = rdy_n | (beats == 3'h1);
  bus_release_snoop bus_release_snoop_i (.CORE_CLK, .RESET, .BUS_RELEASE_REQUEST, .BACKOFF_N,
    .ADDRESS_RELEASE_REQUEST, .EXTERNAL_ADDRESS_STROBE_N, .CACHE_ENABLE_IN_N, .NONBURST_READY_N, .BURST_READY_N,
    .CACHE_WIPE_REQUEST_N, .ADDR_IN, .CYCLE_REQ, .CYCLE_CACHEABLE, .CYCLE_LOCKED, .CYCLE_ADDR, .CYCLE_DONE,
    .BUS_RELEASE_GRANT, .ADDR_OE, .CTRL_OE, .ADDR_OUT, .ADS_N, .LINE_FILL, .LINE_STORE, .INVALIDATE,
    .INVALIDATE_ADDR, .CACHE_FLUSH);
  bus_target_model bus_target_model_i (.clk(CORE_CLK), .ads_n(ADS_N), .beats(beats), .ken_first_n(kf),
    .ken_last_n(kl), .ready_n(rdy_n), .ken_n(CACHE_ENABLE_IN_N));
  always #50 CORE_CLK = ~CORE_CLK;
  // ************
  // monitor and helpers
  // ************
  always @(posedge CORE_CLK) begin
    if (ADS_N === 1'b0) begin
      ads_c++;
      ads_a = ADDR_OUT;
    end
    fill_c += (LINE_FILL === 1'b1);
    store_c += (LINE_STORE === 1'b1);
    done_c += (CYCLE_DONE === 1'b1);
    inv_c += (INVALIDATE === 1'b1);
    fl_c += (CACHE_FLUSH === 1'b1);
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic clr();
    {ads_c, fill_c, store_c, done_c, inv_c, fl_c} = '0;
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task automatic run(logic [31:0] a, logic c, logic [2:0] nb, logic f, logic l, int fill, int store);
    int n = 0;
    clr();
    {CYCLE_ADDR, CYCLE_CACHEABLE, beats, kf, kl, CYCLE_REQ} = {a, c, nb, f, l, 1'b1};
    while (CYCLE_DONE !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    CYCLE_REQ = 0;
    tick(8);
    chk("fill", fill, fill_c);
    chk("store", store, store_c);
    chk("done", 1, done_c);
    chk("start address", a, ads_a);
  endtask
  task automatic t_hold();
    fork
      run(32'h0000_0500, 0, 3'h1, 1, 1, 0, 0);
      begin
        tick(1);
        BUS_RELEASE_REQUEST = 1;
        wait (CYCLE_DONE === 1'b1);
        chk("early grant", 0, BUS_RELEASE_GRANT);
      end
    join
    chk("grant", 1, BUS_RELEASE_GRANT);
    chk("control drive", 0, CTRL_OE);
    BUS_RELEASE_REQUEST = 0;
    tick(6);
    chk("grant off", 0, BUS_RELEASE_GRANT);
    chk("control back", 1, CTRL_OE);
  endtask
  task automatic t_backoff();
    fork
      run(32'h0000_0600, 1, 3'h4, 0, 0, 1, 1);
      begin
        tick(2);
        BACKOFF_N = 0;
        tick(8);
        chk("backoff grant", 0, BUS_RELEASE_GRANT);
        chk("backoff float", 0, CTRL_OE);
        BACKOFF_N = 1;
      end
    join
    chk("starts", 2, ads_c);
  endtask
  task automatic t_locked();
    CYCLE_LOCKED = 1;
    run(32'h0000_0700, 0, 3'h1, 1, 1, 0, 0);
    BUS_RELEASE_REQUEST = 1;
    tick(6);
    chk("locked grant", 0, BUS_RELEASE_GRANT);
    CYCLE_LOCKED = 0;
    tick(6);
    chk("grant after lock", 1, BUS_RELEASE_GRANT);
    BUS_RELEASE_REQUEST = 0;
    tick(6);
    chk("lock grant off", 0, BUS_RELEASE_GRANT);
  endtask
  task automatic t_snoop();
    clr();
    ADDRESS_RELEASE_REQUEST = 1;
    tick(6);
    chk("address drive", 0, ADDR_OE);
    chk("control drive", 1, CTRL_OE);
    ADDR_IN = 32'h0000_1240;
    EXTERNAL_ADDRESS_STROBE_N = 0;
    tick(1);
    EXTERNAL_ADDRESS_STROBE_N = 1;
    tick(6);
    chk("invalidations", 1, inv_c);
    chk("snoop address", 32'h0000_1240, INVALIDATE_ADDR);
    ADDRESS_RELEASE_REQUEST = 0;
    ADDR_IN = ~ADDR_IN;
    tick(6);
    EXTERNAL_ADDRESS_STROBE_N = 0;
    tick(1);
    EXTERNAL_ADDRESS_STROBE_N = 1;
    tick(6);
    chk("stray strobe", 1, inv_c);
    chk("address back", 1, ADDR_OE);
  endtask
  task automatic t_flush();
    clr();
    CACHE_WIPE_REQUEST_N = 0;
    tick(1);
    CACHE_WIPE_REQUEST_N = 1;
    tick(6);
    chk("flush", 1, fl_c);
  endtask
  initial begin
    tick(4);
    RESET = 0;
    tick(3);
    run(32'h0000_0100, 0, 3'h1, 0, 0, 0, 0);
    run(32'h0000_0200, 1, 3'h4, 0, 0, 1, 1);
    run(32'h0000_0300, 1, 3'h4, 0, 1, 1, 0);
    run(32'h0000_0400, 1, 3'h1, 1, 1, 0, 0);
    t_hold();
    t_backoff();
    t_locked();
    t_snoop();
    t_flush();
    end_sim();
  end
  initial begin
    #300000;
    miscompares++;
    end_sim();
  end
endmodule
